/* verilog/hs_switch_params.svh */
/*
 * Constants of the switch mode and channel control block: register bit
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef HS_SWITCH_PARAMS_SVH
`define HS_SWITCH_PARAMS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define REF_CLK_HZ          10000000
`define WATCHDOG_TIMEOUT_MS 310
`define INPUT_IDLE_TIMEOUT_MS 250
`define WATCHDOG_CYCLES     ((`REF_CLK_HZ / 1000) * `WATCHDOG_TIMEOUT_MS)
`define INPUT_IDLE_CYCLES   ((`REF_CLK_HZ / 1000) * `INPUT_IDLE_TIMEOUT_MS)

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define GCR_WATCHDOG_DISABLE_BIT_BIT      4
`define GCR_RESET           8'h00
`define PULSE_WIDTH_REGISTER_DUTY_MSB       7
`define PULSE_WIDTH_REGISTER_DUTY_LSB       0
`define PULSE_WIDTH_REGISTER_RESET          8'h00
`define SLEW_DEFAULT        2'h0
`define DELAY_DEFAULT       2'h0

`endif

/* verilog/hs_switch_pkg.sv */
/*
 * Types of the switch mode and channel control block.
 * Assumes hs_switch_params.svh is on the include path.
 */
package hs_switch_pkg;
	// operating mode, one-hot
	typedef enum logic [3:0] {
		MODE_SLEEP    = 4'h1,
		MODE_NORMAL   = 4'h2,
		MODE_FAILSAFE = 4'h4,
		MODE_FAULT    = 4'h8
	} mode_type;

	// recovery from fail-safe, one-hot
	typedef enum logic [2:0] {
		REC_IDLE  = 3'h1,
		REC_ARMED = 3'h2,
		REC_DONE  = 3'h4
	} recover_type;
endpackage

/* verilog/switch_mode_and_channel_control.sv */
/*
 * Mode controller and channel target logic of a dual high-side switch.
 * Word strobes from the serial link arrive in the link clock domain;
 * everything else is on ref_clk_i. Pins come from outside and are
 * synchronised here. Analog fault detectors are plain level inputs.
 */
`timescale 1ns/100ps
`include "hs_switch_params.svh"

module switch_mode_and_channel_control #(
	parameter int WD_CYCLES   = `WATCHDOG_CYCLES,   // watchdog terminal count
	parameter int IDLE_CYCLES = `INPUT_IDLE_CYCLES, // input idle terminal count
	parameter int CH          = 2                   // channel count
) (
	input  wire logic          ref_clk_i,             // 10 MHz core clock
	input  wire logic          nrst_i,                // async reset, active low
	input  wire logic          link_clk_i,            // serial link clock
	input  wire logic          word_strobe_i,         // link: word received
	input  wire logic          watchdog_toggle_bit_i, // link: first bit of word
	input  wire logic          wake_reset_pad_i,      // pin, reset release
	input  wire logic [CH-1:0] direct_in_i,           // pins, direct inputs
	input  wire logic          logic_supply_ok_i,     // pin, logic supply present
	input  wire logic          supply_fail_en_i,      // supply-loss fail-safe enable
	input  wire logic [7:0]    global_config_register_i, // config, D4 = wd disable
	input  wire logic [CH-1:0] on_bit_i,              // per-channel on bits
	input  wire logic [CH-1:0] pwm_en_i,              // per-channel PWM enable
	input  wire logic [CH-1:0] dir_dis_i,             // per-channel direct disable
	input  wire logic [CH-1:0] clock_int_i,           // per-channel internal clk sel
	input  wire logic [CH*8-1:0] pulse_width_register_i, // duty per channel
	input  wire logic          ext_pwm_clk_i,         // pin, external PWM clock
	input  wire logic [CH-1:0] current_limit_fault_i, // per-channel overcurrent
	input  wire logic [CH-1:0] thermal_fault_i,       // per-channel overtemp
	input  wire logic [CH-1:0] severe_short_fault_i,  // per-channel short
	input  wire logic          supply_low_fault_i,    // undervoltage
	input  wire logic          supply_high_fault_i,   // overvoltage
	input  wire logic          supply_high_qualifier_i, // overvoltage qualify
	output logic [3:0]         mode_o,                // one-hot mode
	output logic               normal_mode_flag_o,    // normal mode status
	output logic [CH-1:0]      hs_on_o,               // target channel on-state
	output logic [1:0]         slew_code_o,           // slew code, default when direct
	output logic [1:0]         delay_code_o,          // turn-on delay code
	output logic               failsafe_flag_pad_o,   // open drain data, always 0
	output logic               failsafe_flag_pad_oe_o, // high while pulling low
	output logic               reg_reset_o,           // pulse: reset registers
	output logic [CH*2-1:0]    channel_state_register_o, // {fault,on} per ch
	output logic [CH*3-1:0]    channel_fault_register_o  // {sc,ot,oc} per ch
);

	// ---------------------------------------------------------------
	// link domain: capture word toggle bit and announce with a toggle
	// ---------------------------------------------------------------
	logic lnk_evt_q;
	logic lnk_bit_q;

	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lnk_evt_q <= 1'b0;
			lnk_bit_q <= 1'b0;
		end else if (word_strobe_i) begin
			lnk_evt_q <= ~lnk_evt_q;
			lnk_bit_q <= watchdog_toggle_bit_i;
		end
	end

	// ---------------------------------------------------------------
	// synchronisers
	// ---------------------------------------------------------------
	// bit and event change together; the event is used one cycle late
	// so that the bit beside it has settled even if the two resolve apart
	// (words must be spaced by several core cycles for this to hold)
	logic [4+CH:0] sy1_q;
	logic [4+CH:0] sy2_q;
	wire  [4+CH:0] sy_in = {ext_pwm_clk_i, lnk_bit_q, lnk_evt_q, logic_supply_ok_i,
		wake_reset_pad_i, direct_in_i};

	// two flops before any reader
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= sy_in;
			sy2_q <= sy1_q;
		end
	end

	wire [CH-1:0] din_s   = sy2_q[CH-1:0];
	wire          pad_s   = sy2_q[CH];
	wire          vdd_s   = sy2_q[CH+1];
	wire          evt_s   = sy2_q[CH+2];
	wire          wbit_s  = sy2_q[CH+3];
	wire          extclk_s = sy2_q[CH+4];

	// edge history of synchronised levels
	logic [CH-1:0] din_prev_q;
	logic          pad_prev_q;
	logic          evt_prev_q;
	logic          evt_prev2_q;
	logic          vdd_seen_q;
	logic          extclk_prev_q;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			din_prev_q    <= '0;
			pad_prev_q    <= 1'b0;
			evt_prev_q    <= 1'b0;
			evt_prev2_q   <= 1'b0;
			vdd_seen_q    <= 1'b0;
			extclk_prev_q <= 1'b0;
		end else begin
			din_prev_q    <= din_s;
			pad_prev_q    <= pad_s;
			evt_prev_q    <= evt_s;
			evt_prev2_q   <= evt_prev_q;
			vdd_seen_q    <= vdd_seen_q | vdd_s;
			extclk_prev_q <= extclk_s;
		end
	end

	wire          word_rx  = evt_prev_q ^ evt_prev2_q;
	wire          pad_rise = pad_s & ~pad_prev_q;
	wire [CH-1:0] din_rise = din_s & ~din_prev_q;
	wire [CH-1:0] din_edge = din_s ^ din_prev_q;

	// ---------------------------------------------------------------
	// direct input activity flags
	// ---------------------------------------------------------------
	logic [CH-1:0] in_on_q;

	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : g_idle
			logic [31:0] idle_cnt_q;
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					idle_cnt_q <= '0;
					in_on_q[g] <= 1'b0;
				end else if (din_edge[g] || din_s[g]) begin
					idle_cnt_q <= '0;
					in_on_q[g] <= in_on_q[g] | din_rise[g];
				end else if (idle_cnt_q >= 32'(IDLE_CYCLES)) begin
					in_on_q[g] <= 1'b0;
				end else begin
					idle_cnt_q <= idle_cnt_q + 32'h1;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	logic        watchdog_disable_bit;
	logic        wd_run;
	logic        wd_to_q;
	logic        last_wbit_q;
	logic [31:0] wd_cnt_q;
	hs_switch_pkg::recover_type rec_q;
	hs_switch_pkg::mode_type    mode_q;

	assign watchdog_disable_bit = global_config_register_i[`GCR_WATCHDOG_DISABLE_BIT_BIT];
	assign wd_run = vdd_s & ~watchdog_disable_bit & pad_s;

	wire toggled = word_rx & (wbit_s != last_wbit_q);
	// once timed out, a toggle no longer clears the timeout; recovery, a pad rise or a stopped watchdog does
	wire wd_clr  = !wd_run || pad_rise || (toggled && !wd_to_q)
		|| rec_q == hs_switch_pkg::REC_DONE;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_cnt_q    <= '0;
			wd_to_q     <= 1'b0;
			last_wbit_q <= 1'b0;
		end else begin
			if (word_rx)
				last_wbit_q <= wbit_s;
			if (wd_clr) begin
				wd_cnt_q <= '0;
				wd_to_q  <= 1'b0;
			end else if (wd_cnt_q >= 32'(WD_CYCLES)) begin
				wd_to_q <= 1'b1;
			end else begin
				wd_cnt_q <= wd_cnt_q + 32'h1;
			end
		end
	end

	// recovery: toggle-1 word then a second within timeout
	logic [31:0] rec_cnt_q;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rec_q     <= hs_switch_pkg::REC_IDLE;
			rec_cnt_q <= '0;
		end else begin
			unique case (rec_q)
				hs_switch_pkg::REC_IDLE: begin
					rec_cnt_q <= '0;
					if (wd_to_q && word_rx && wbit_s)
						rec_q <= hs_switch_pkg::REC_ARMED;
				end
				hs_switch_pkg::REC_ARMED: begin
					rec_cnt_q <= rec_cnt_q + 32'h1;
					if (word_rx)
						rec_q <= hs_switch_pkg::REC_DONE;
					else if (rec_cnt_q >= 32'(WD_CYCLES))
						rec_q <= hs_switch_pkg::REC_IDLE;
				end
				hs_switch_pkg::REC_DONE: rec_q <= hs_switch_pkg::REC_IDLE;
				default: rec_q <= hs_switch_pkg::REC_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// mode terms and decode
	// ---------------------------------------------------------------
	logic wake;
	logic vdd_fail;
	logic failsafe;
	logic fault;
	assign wake     = pad_s | (|in_on_q);
	// supply loss only after presence, when enabled
	assign vdd_fail = vdd_seen_q & ~vdd_s & supply_fail_en_i;
	assign failsafe = vdd_fail | (wd_to_q & ~watchdog_disable_bit);
	assign fault = (|current_limit_fault_i) | (|thermal_fault_i) | (|severe_short_fault_i)
		| supply_low_fault_i | (supply_high_fault_i & supply_high_qualifier_i);

	hs_switch_pkg::mode_type mode_d;
	// sleep; both idle with pad low
	always_comb begin
		if (!wake)
			mode_d = hs_switch_pkg::MODE_SLEEP;
		else if (fault)
			mode_d = hs_switch_pkg::MODE_FAULT;
		else if (failsafe)
			mode_d = hs_switch_pkg::MODE_FAILSAFE;
		else
			mode_d = hs_switch_pkg::MODE_NORMAL;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			mode_q <= hs_switch_pkg::MODE_SLEEP;
		else
			mode_q <= mode_d;
	end

	wire is_norm = (mode_q == hs_switch_pkg::MODE_NORMAL);
	wire is_fs   = (mode_q == hs_switch_pkg::MODE_FAILSAFE);
	wire enter_fs = (mode_d == hs_switch_pkg::MODE_FAILSAFE) && !is_fs;

	// ---------------------------------------------------------------
	// channel target and PWM
	// ---------------------------------------------------------------
	logic [7:0]    phase_q;
	logic [7:0]    ext_phase_q;
	logic [CH-1:0] hs_on_d;
	logic [CH-1:0] duty_act;
	logic [CH-1:0] dir_only;

	// free-running phases for internal and external clocks
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_q     <= 8'h00;
			ext_phase_q <= 8'h00;
		end else begin
			phase_q <= phase_q + 8'h01;
			if (extclk_s && !extclk_prev_q)
				ext_phase_q <= ext_phase_q + 8'h01;
		end
	end

	generate
		for (g = 0; g < CH; g++) begin : g_ch
			wire [7:0] duty = pulse_width_register_i[g*8 + `PULSE_WIDTH_REGISTER_DUTY_MSB : g*8 + `PULSE_WIDTH_REGISTER_DUTY_LSB];
			wire [7:0] ph = clock_int_i[g] ? phase_q : ext_phase_q;
			assign duty_act[g] = (ph < duty);
			// pad low or fail-safe: direct only
			assign dir_only[g] = !pad_s || is_fs;
			assign hs_on_d[g] = dir_only[g] ? din_s[g] :
				((din_s[g] & ~dir_dis_i[g]) | (on_bit_i[g] & pwm_en_i[g] & duty_act[g])
				| (on_bit_i[g] & ~pwm_en_i[g]));
		end
	endgenerate

	// channels off outside normal and fail-safe
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			hs_on_o <= '0;
		else
			hs_on_o <= (is_norm || is_fs) ? hs_on_d : '0;
	end

	// default slew and delay in direct mode, limitation: one code shared
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slew_code_o  <= `SLEW_DEFAULT;
			delay_code_o <= `DELAY_DEFAULT;
		end else begin
			slew_code_o  <= `SLEW_DEFAULT;
			delay_code_o <= `DELAY_DEFAULT;
		end
	end

	// ---------------------------------------------------------------
	// status outputs
	// ---------------------------------------------------------------
	// state and fault type; flag; pad and reset
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			normal_mode_flag_o       <= 1'b0;
			failsafe_flag_pad_oe_o   <= 1'b0;
			reg_reset_o              <= 1'b0;
			channel_state_register_o <= '0;
			channel_fault_register_o <= '0;
		end else begin
			normal_mode_flag_o     <= (mode_d == hs_switch_pkg::MODE_NORMAL);
			failsafe_flag_pad_oe_o <= (mode_d == hs_switch_pkg::MODE_FAILSAFE)
				|| (failsafe && wake);
			reg_reset_o            <= enter_fs || (rec_q == hs_switch_pkg::REC_DONE);
			for (int i = 0; i < CH; i++) begin
				channel_state_register_o[i*2]   <= hs_on_o[i];
				channel_state_register_o[i*2+1] <= current_limit_fault_i[i]
					| thermal_fault_i[i] | severe_short_fault_i[i];
				channel_fault_register_o[i*3]   <= current_limit_fault_i[i];
				channel_fault_register_o[i*3+1] <= thermal_fault_i[i];
				channel_fault_register_o[i*3+2] <= severe_short_fault_i[i];
			end
		end
	end

	assign mode_o              = mode_q;
	assign failsafe_flag_pad_o = 1'b0; // open drain only pulls low

endmodule // switch_mode_and_channel_control

/* verification/switch_mode_and_channel_control_properties.sv */
/*
 * Concurrent checks on the ports of the mode controller.
 * Assumes a bind onto the design top; all checks on ref_clk_i.
 */
`timescale 1ns/100ps

module hs_mode_checker #(
	parameter int CH = 2	// channel count
) (
	input wire logic		ref_clk_i,		// core clock
	input wire logic		nrst_i,			// reset, low
	input wire logic		wake_reset_pad_i,	// wake pin
	input wire logic [CH-1:0]	direct_in_i,		// direct pins
	input wire logic [CH-1:0]	current_limit_fault_i,	// overcurrent
	input wire logic [CH-1:0]	thermal_fault_i,	// overtemp
	input wire logic [CH-1:0]	severe_short_fault_i,	// short
	input wire logic		supply_low_fault_i,	// low supply
	input wire logic		supply_high_fault_i,	// high supply
	input wire logic		supply_high_qualifier_i,	// high qualify
	input wire logic [3:0]		mode_o,			// one-hot mode
	input wire logic		normal_mode_flag_o,	// normal flag
	input wire logic [CH-1:0]	hs_on_o,		// channel targets
	input wire logic		failsafe_flag_pad_oe_o,	// pad pull
	input wire logic		reg_reset_o		// register reset
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	// any fault source; high supply counts only when qualified
	wire logic flt_w = |{current_limit_fault_i, thermal_fault_i, severe_short_fault_i,
		supply_low_fault_i, supply_high_fault_i & supply_high_qualifier_i};

	// --------------------------------------------------------------
	// sequences and properties
	// --------------------------------------------------------------
	sequence s_pad_rise;
		!wake_reset_pad_i ##1 wake_reset_pad_i [*5];
	endsequence
	sequence s_fs_enter;
		(mode_o == 4'h2) ##1 (mode_o == 4'h4);
	endsequence
	// two cycles of margin: outputs settle one edge after the mode
	property p_sleep_off;
		(mode_o == 4'h1) [*2] |-> hs_on_o == '0;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep");
	property p_nm_flag;
		normal_mode_flag_o == (mode_o == 4'h2);
	endproperty
	a_nm_flag: assert property (p_nm_flag) else $error("normal flag wrong");
	property p_fs_direct;
		(mode_o == 4'h4 && $stable(direct_in_i)) [*5] |-> hs_on_o == direct_in_i;
	endproperty
	a_fs_direct: assert property (p_fs_direct) else $error("fail-safe not direct");
	property p_fault_off;
		(mode_o == 4'h8) [*2] |-> hs_on_o == '0;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("channel on in fault");
	property p_fault_terms;
		(flt_w && wake_reset_pad_i) [*6] |-> mode_o == 4'h8;
	endproperty
	a_fault_terms: assert property (p_fault_terms) else $error("fault not entered");
	property p_pad_wake;
		s_pad_rise |-> mode_o != 4'h1;
	endproperty
	a_pad_wake: assert property (p_pad_wake) else $error("pad rise no wake");
	property p_fs_pad;
		(mode_o == 4'h4) [*2] |-> failsafe_flag_pad_oe_o;
	endproperty
	a_fs_pad: assert property (p_fs_pad) else $error("fail-safe pad idle");
	property p_fs_entry;
		s_fs_enter |-> reg_reset_o || $past(reg_reset_o);
	endproperty
	a_fs_entry: assert property (p_fs_entry) else $error("no register reset");
	property p_rr_pulse;
		reg_reset_o |=> !reg_reset_o;
	endproperty
	a_rr_pulse: assert property (p_rr_pulse) else $error("reset pulse too long");
	property p_nm_release;
		(mode_o == 4'h2) [*2] |-> !failsafe_flag_pad_oe_o;
	endproperty
	a_nm_release: assert property (p_nm_release) else $error("pad pulled in normal");
endmodule // hs_mode_checker

bind switch_mode_and_channel_control hs_mode_checker #(.CH(CH)) u_hs_mode_checker (
	.ref_clk_i, .nrst_i, .wake_reset_pad_i, .direct_in_i, .current_limit_fault_i,
	.thermal_fault_i, .severe_short_fault_i, .supply_low_fault_i, .supply_high_fault_i,
	.supply_high_qualifier_i, .mode_o, .normal_mode_flag_o, .hs_on_o,
	.failsafe_flag_pad_oe_o, .reg_reset_o);

/* verification/host_link_model.sv */
/*
 * Host side of the serial link: sends words carrying the toggle bit.
 * Assumes a free running link clock from the bench.
 */
`timescale 1ns/100ps

module host_link_model (
	input  wire logic	link_clk_i,	// link clock
	output logic		word_strobe_o,	// one cycle a word
	output logic		toggle_bit_o	// first word bit
);
	logic b = 1'b0;

	initial begin
		word_strobe_o = 1'b0;
		toggle_bit_o = 1'b1;
	end
	// first bit rides with the strobe; inverse once released
	task automatic send_word(input logic v);
		@(posedge link_clk_i);
		#1;
		word_strobe_o = 1'b1;
		toggle_bit_o = v;
		@(posedge link_clk_i);
		#1;
		word_strobe_o = 1'b0;
		toggle_bit_o = ~v;
	endtask
	// alternate the bit well inside the timeout
	task automatic keep_alive(input int k);
		repeat (k) begin
			b = ~b;
			#10000;
			send_word(b);
		end
	endtask
	// a one word, then a second word in time
	task automatic recover;
		send_word(1'b1);
		#1000;
		send_word(1'b0);
	endtask
endmodule // host_link_model

/* verification/test_switch_mode_and_channel_control.sv */
/*
 * Self-checking bench of the mode controller with a host link model.
 * Assumes short terminal counts; watchdog 200 and idle 150 cycles.
 */
`timescale 1ns/100ps

module test_switch_mode_and_channel_control;
	localparam int WD = 200;
	localparam int IDLE = 150;
	// fault sources {oc0,ot1,sc0,low,high,qual}; last one is unqualified
	localparam logic [5:0] FT [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h03, 6'h02};
	logic ref_clk_i = 1'b0, link_clk_i, nrst_i = 1'b0, wake_reset_pad_i = 1'b0;
	logic logic_supply_ok_i = 1'b1, supply_fail_en_i = 1'b0, ext_pwm_clk_i = 1'b0;
	logic [1:0] direct_in_i = '0, on_bit_i = '0, pwm_en_i = '0, dir_dis_i = '0;
	logic [1:0] clock_int_i = '0, current_limit_fault_i = '0, thermal_fault_i = '0;
	logic [1:0] severe_short_fault_i = '0;
	logic supply_low_fault_i = 1'b0, supply_high_fault_i = 1'b0;
	logic supply_high_qualifier_i = 1'b0;
	logic [7:0] global_config_register_i = '0;
	logic [15:0] pulse_width_register_i = '0;
	logic [3:0] mode_o, channel_state_register_o;
	logic [1:0] hs_on_o, slew_code_o, delay_code_o;
	logic [5:0] channel_fault_register_o;
	logic normal_mode_flag_o, failsafe_flag_pad_o, failsafe_flag_pad_oe_o, reg_reset_o;
	wire logic word_strobe_i, watchdog_toggle_bit_i;
	int miscompares = 0, n_tests = 0, n, n0, n1;

	always #50 ref_clk_i = ~ref_clk_i;
	always #700 ext_pwm_clk_i = ~ext_pwm_clk_i;
	// link clock offset so its phase drifts against the core clock
	initial begin
		link_clk_i = 1'b0;
		#1.3;
		forever #3 link_clk_i = ~link_clk_i;
	end

	switch_mode_and_channel_control #(.WD_CYCLES(WD), .IDLE_CYCLES(IDLE))
		u_switch_mode_and_channel_control (.*);
	host_link_model u_host_link_model (.link_clk_i(link_clk_i),
		.word_strobe_o(word_strobe_i), .toggle_bit_o(watchdog_toggle_bit_i));

	// --------------------------------------------------------------
	// model, compare and sequencing tasks
	// --------------------------------------------------------------
	// mode table: wake, then fault, then fail-safe
	function automatic logic [3:0] md(input int w, input int f, input int t);
		if (w == 0) return 4'h1;
		if (t != 0) return 4'h8;
		return (f != 0) ? 4'h4 : 4'h2;
	endfunction
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait; a hang ends the run as a mismatch
	task automatic wait_mode(input logic [3:0] m, input int lim);
		n = 0;
		while (mode_o !== m) begin
			step(1);
			n++;
			if (n > lim) begin
				miscompares++;
				close_out();
			end
		end
	endtask
	task automatic do_reset;
		nrst_i = 1'b0;
		step(2);
		nrst_i = 1'b1;
		step(2);
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	initial begin
		n = $urandom(53);
		step(1);
		do_reset();
		chk("mode", mode_o, md(0, 0, 0));
		chk("hs_on", hs_on_o, 8'h00);
		wake_reset_pad_i = 1'b1;
		step(5);
		chk("mode", mode_o, md(1, 0, 0));
		chk("nm_flag", normal_mode_flag_o, 8'h01);
		// zero duty never active: only direct and pwm-off terms switch on
		repeat (8) begin
			{on_bit_i, pwm_en_i, dir_dis_i, clock_int_i, direct_in_i} = 10'($urandom);
			step(4);
			chk("hs_on", hs_on_o, direct_in_i & ~dir_dis_i | on_bit_i & ~pwm_en_i);
		end
		// long duty count: watchdog off or it would expire meanwhile
		global_config_register_i = 8'h10;
		{on_bit_i, pwm_en_i, clock_int_i, dir_dis_i, direct_in_i} = 10'h3f0;
		pulse_width_register_i = 16'h4080;
		step(4);
		n0 = 0;
		n1 = 0;
		repeat (256) begin
			step(1);
			if (hs_on_o[0] === 1'b1) n0++;
			if (hs_on_o[1] === 1'b1) n1++;
		end
		chk("duty0", 8'(n0), 8'h80);
		chk("duty1", 8'(n1), 8'h40);
		// ch0 on the external clock: 256 of its periods, 14 core cycles each
		clock_int_i = 2'h2;
		step(4);
		n0 = 0;
		repeat (3584) begin
			step(1);
			if (hs_on_o[0] === 1'b1) n0++;
		end
		chk("ext_duty0", 8'(n0 / 14), 8'h80);
		chk("slew_delay", {slew_code_o, delay_code_o}, 8'h00);
		chk("mode", mode_o, md(1, 0, 0));
		global_config_register_i = 8'h00;
		u_host_link_model.keep_alive(4);
		chk("mode", mode_o, md(1, 0, 0));
		wait_mode(4'h4, WD + 20);
		chk("wd_late", 8'(n > WD - 20), 8'h01);
		chk("fs_pad", failsafe_flag_pad_oe_o, 8'h01);
		chk("fs_data", failsafe_flag_pad_o, 8'h00);
		// pad stays high while the bench drives direct inputs slowly
		repeat (4) begin
			direct_in_i = 2'($urandom);
			step(5);
			chk("hs_on", hs_on_o, direct_in_i);
		end
		supply_low_fault_i = 1'b1;
		step(6);
		chk("mode", mode_o, md(1, 1, 1));
		supply_low_fault_i = 1'b0;
		direct_in_i = 2'h0;
		step(6);
		u_host_link_model.recover();
		wait_mode(4'h2, 40);
		chk("fs_pad", failsafe_flag_pad_oe_o, 8'h00);
		global_config_register_i = 8'h10;
		for (int i = 0; i < 6; i++) begin
			{current_limit_fault_i[0], thermal_fault_i[1], severe_short_fault_i[0],
				supply_low_fault_i, supply_high_fault_i, supply_high_qualifier_i} = FT[i];
			step(6);
			chk("mode", mode_o, md(1, 0, i < 5));
			// fault types per channel {sc,ot,oc}, state fault bits {f1,-,f0,-}
			n = {FT[i][4], 1'b0, FT[i][3], 1'b0, FT[i][5]};
			n1 = {FT[i][4], 1'b0, FT[i][5] | FT[i][3], 1'b0};
			chk("flt_reg", channel_fault_register_o, 8'(n));
			chk("st_flt", channel_state_register_o & 4'ha, 8'(n1));
			{current_limit_fault_i, thermal_fault_i, severe_short_fault_i} = '0;
			{supply_low_fault_i, supply_high_fault_i, supply_high_qualifier_i} = '0;
			step(6);
		end
		supply_fail_en_i = 1'b1;
		logic_supply_ok_i = 1'b0;
		wait_mode(4'h4, 10);
		chk("mode", mode_o, md(1, 1, 0));
		{logic_supply_ok_i, supply_fail_en_i, wake_reset_pad_i} = 3'h4;
		do_reset();
		direct_in_i = 2'h2;
		step(1);
		direct_in_i = 2'h0;
		wait_mode(4'h2, 10);
		chk("mode", mode_o, md(1, 0, 0));
		wait_mode(4'h1, IDLE + 20);
		chk("idle_late", 8'(n > IDLE - 20), 8'h01);
		chk("hs_on", hs_on_o, 8'h00);
		close_out();
	end
endmodule // test_switch_mode_and_channel_control
